// file: rtl/rxls_pkg.sv
package rxls_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] RXLS_OFF_RFS = 8'h00;
  localparam logic [7:0] RXLS_OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] RXLS_OFF_IRQ_CLR = 8'h08;
  localparam logic [7:0] RXLS_OFF_IRQ_EN = 8'h0C;
  localparam int RXLS_ADDR_W = 8;

  // ---------------------------------------------------------------
  // Field layout of receive_filter_and_status
  // ---------------------------------------------------------------
  localparam int RXLS_REG_W = 16;
  localparam int RXLS_CTRL_LSB = 9;
  localparam int RXLS_CTRL_W = 7;
  localparam int RXLS_FLAG_W = 9;
  localparam int RXLS_LB_LSB = 9;
  localparam int RXLS_BIT_MC = 8;
  localparam int RXLS_BIT_BC = 7;
  localparam int RXLS_BIT_LAST = 6;
  localparam int RXLS_BIT_CRS = 5;
  localparam int RXLS_BIT_COL = 4;
  localparam int RXLS_BIT_CRC = 3;
  localparam int RXLS_BIT_ALIGN = 2;
  localparam int RXLS_BIT_LBK = 1;
  localparam int RXLS_BIT_OK = 0;
  localparam logic [RXLS_CTRL_W-1:0] RXLS_CTRL_RST = 7'h00;
  localparam logic [RXLS_FLAG_W-1:0] RXLS_FLAG_RST = 9'h000;
  // Flags wiped when the next frame starts: bits 8..6 and 3..0.
  localparam logic [RXLS_FLAG_W-1:0] RXLS_FLAG_CLR_MASK = 9'h1CF;

  // ---------------------------------------------------------------
  // Interrupt layout
  // ---------------------------------------------------------------
  localparam int RXLS_IRQ_W = 4;
  localparam int RXLS_IRQ_DONE = 0;
  localparam int RXLS_IRQ_OK = 1;
  localparam int RXLS_IRQ_ERR = 2;
  localparam int RXLS_IRQ_LAST = 3;
  localparam logic [RXLS_IRQ_W-1:0] RXLS_IRQ_RST = 4'h0;

  // ---------------------------------------------------------------
  // Frame and bus constants
  // ---------------------------------------------------------------
  localparam int RXLS_RUNT_BYTES = 64;
  localparam int RXLS_CNT_W = 7;
  localparam logic [1:0] RXLS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RXLS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RXLS_LB_NONE,
    RXLS_LB_MAC,
    RXLS_LB_LINE_ENCODER_DECODER,
    RXLS_LB_XCVR
  } rxls_lb_e;

endpackage

// file: rtl/rxls_stat_if.sv
`timescale 1ns/1ps
interface rxls_stat_if;
  import rxls_pkg::*;

  // Per-frame status flags and frame events from the evaluator.
  logic [RXLS_FLAG_W-1:0] flags;
  logic done;
  logic accepted;
  logic ok;
  logic err;
  // Loopback mode selected by software, for the loopback flag.
  rxls_lb_e lb_mode;

  modport eval (
    output flags,
    output done,
    output accepted,
    output ok,
    output err,
    input lb_mode
  );

  modport regs (
    input flags,
    input done,
    input accepted,
    input ok,
    input err,
    output lb_mode
  );
endinterface

// file: rtl/rxls_frame_eval.sv
`timescale 1ns/1ps
module rxls_frame_eval
  import rxls_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rx_frame_start,
  input wire logic rx_frame_end,
  input wire logic rx_byte_valid,
  input wire logic rx_dest_multicast,
  input wire logic rx_dest_broadcast,
  input wire logic rx_crc_bad,
  input wire logic rx_odd_bits,
  input wire logic rx_collision,
  input wire logic rx_accept,
  input wire logic [15:0] remaining_buffer_words,
  input wire logic [15:0] end_of_buffer_threshold,
  input wire logic carrier_sync,
  rxls_stat_if.eval st
);

  // ---------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------
  logic in_frame_reg;
  logic coll_seen_reg;
  logic [RXLS_CNT_W-1:0] byte_cnt_reg;
  logic [RXLS_FLAG_W-1:0] flags_reg;
  logic done_reg, acc_reg, ok_reg, err_reg;

  // Counter saturates at the runt limit so long frames cannot wrap.
  localparam logic [RXLS_CNT_W-1:0] RUNT_CNT = RXLS_CNT_W'(RXLS_RUNT_BYTES);
  wire cnt_sat = (byte_cnt_reg >= RUNT_CNT);
  wire [RXLS_CNT_W-1:0] cnt_now = (rx_byte_valid && !cnt_sat) ?
    byte_cnt_reg + 7'h01 : byte_cnt_reg;
  wire frame_end = in_frame_reg && rx_frame_end;
  wire coll_any = coll_seen_reg || rx_collision;
  wire is_runt = (cnt_now < RUNT_CNT);
  wire crc_only = rx_crc_bad && !rx_odd_bits;
  wire align_err = rx_crc_bad && rx_odd_bits;
  wire frame_ok = !rx_crc_bad && !is_runt && !coll_any;
  wire lbk_ok = frame_ok && (st.lb_mode != RXLS_LB_NONE);
  wire last_buf = (remaining_buffer_words <= end_of_buffer_threshold);

  // Frame state, byte count and collision memory.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_frame_reg <= 1'b0;
      coll_seen_reg <= 1'b0;
      byte_cnt_reg <= '0;
    end else if (rx_frame_start) begin
      in_frame_reg <= 1'b1;
      coll_seen_reg <= rx_collision;
      byte_cnt_reg <= rx_byte_valid ? 7'h01 : 7'h00;
    end else if (in_frame_reg) begin
      in_frame_reg <= !rx_frame_end;
      coll_seen_reg <= coll_any;
      byte_cnt_reg <= cnt_now;
    end
  end

  // Status flags; carrier bit follows the synchronised sense line.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_reg <= RXLS_FLAG_RST;
    end else begin
      flags_reg[RXLS_BIT_CRS] <= carrier_sync;
      if (rx_frame_start) begin
        flags_reg[8:6] <= 3'h0;
        flags_reg[3:0] <= 4'h0;
      end else if (frame_end) begin
        flags_reg[RXLS_BIT_MC] <= rx_dest_multicast;
        flags_reg[RXLS_BIT_BC] <= rx_dest_broadcast;
        flags_reg[RXLS_BIT_LAST] <= last_buf;
        flags_reg[RXLS_BIT_COL] <= coll_any;
        flags_reg[RXLS_BIT_CRC] <= crc_only;
        flags_reg[RXLS_BIT_ALIGN] <= align_err;
        flags_reg[RXLS_BIT_LBK] <= lbk_ok;
        flags_reg[RXLS_BIT_OK] <= frame_ok;
      end
    end
  end

  // One-cycle frame events, aligned with the updated flags.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
      acc_reg <= 1'b0;
      ok_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      done_reg <= frame_end;
      acc_reg <= frame_end && rx_accept;
      ok_reg <= frame_end && frame_ok;
      err_reg <= frame_end && !frame_ok;
    end
  end

  assign st.flags = flags_reg;
  assign st.done = done_reg;
  assign st.accepted = acc_reg;
  assign st.ok = ok_reg;
  assign st.err = err_reg;

endmodule

// file: rtl/rxls_top.sv
// Contract
// - Loopback field picks none, MAC, encoder/decoder or transceiver.
// - Multicast destination sets bit 8.
// - Broadcast destination sets bit 7.
// - Bit 6 set when remaining buffer words not above threshold.
// - Bit 5 shows carrier sense activity.
// - Bit 4 set when any collision occurred during the frame.
// - Bit 3 marks bad CRC, unless alignment error also occurred.
// - Bit 2 set only for misaligned frames that also fail CRC.
// - Bit 1 set when a loopback frame returns successfully.
// - Bit 0 set only for frames free of CRC, runt, collision.
// - Bits 8..6 and 3..0 clear when the next frame starts.
// - Accepted frame copies the whole register into its descriptor status.
// - Frames under 64 bytes are runts and never flagged good.
// - Software reset leaves the register untouched.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module rxls_top
  import rxls_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  // AXI4-Lite slave.
  input wire logic [RXLS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [RXLS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Receive path.
  input wire logic rx_frame_start,
  input wire logic rx_frame_end,
  input wire logic rx_byte_valid,
  input wire logic rx_dest_multicast,
  input wire logic rx_dest_broadcast,
  input wire logic rx_crc_bad,
  input wire logic rx_odd_bits,
  input wire logic rx_collision,
  input wire logic rx_accept,
  input wire logic [15:0] remaining_buffer_words,
  input wire logic [15:0] end_of_buffer_threshold,
  input wire logic carrier_sense_pin,
  // Loopback steering and descriptor write-back.
  output logic loopback_mac,
  output logic loopback_line_encoder_decoder,
  output logic loopback_xcvr,
  output logic [RXLS_REG_W-1:0] descriptor_status_word,
  output logic descriptor_status_valid,
  output logic irq
);

  // ---------------------------------------------------------------
  // Carrier sense synchroniser
  // ---------------------------------------------------------------
  logic crs_meta_reg;
  logic crs_sync_reg;

  // The pin is asynchronous; only the second stage is used.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      crs_meta_reg <= 1'b0;
      crs_sync_reg <= 1'b0;
    end else begin
      crs_meta_reg <= carrier_sense_pin;
      crs_sync_reg <= crs_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Frame evaluator
  // ---------------------------------------------------------------
  rxls_stat_if st ();

  rxls_frame_eval u_eval (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .rx_frame_start (rx_frame_start),
    .rx_frame_end (rx_frame_end),
    .rx_byte_valid (rx_byte_valid),
    .rx_dest_multicast (rx_dest_multicast),
    .rx_dest_broadcast (rx_dest_broadcast),
    .rx_crc_bad (rx_crc_bad),
    .rx_odd_bits (rx_odd_bits),
    .rx_collision (rx_collision),
    .rx_accept (rx_accept),
    .remaining_buffer_words (remaining_buffer_words),
    .end_of_buffer_threshold (end_of_buffer_threshold),
    .carrier_sync (crs_sync_reg),
    .st (st)
  );

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [RXLS_CTRL_W-1:0] ctrl_reg;
  logic [RXLS_IRQ_W-1:0] irq_stat_reg;
  logic [RXLS_IRQ_W-1:0] irq_en_reg;

  wire [RXLS_REG_W-1:0] rfs_value = {ctrl_reg, st.flags};
  assign st.lb_mode = rxls_lb_e'(ctrl_reg[1:0]);

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic awready_reg, wready_reg, bvalid_reg;
  logic [1:0] bresp_reg;
  logic [RXLS_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  wire aw_hs = s_axi_awvalid && awready_reg;
  wire w_hs = s_axi_wvalid && wready_reg;
  // Address and data may arrive in either order; write once both held.
  wire do_write = !awready_reg && !wready_reg && !bvalid_reg;
  wire wr_rfs = do_write && (awaddr_reg == RXLS_OFF_RFS);
  wire wr_clr = do_write && (awaddr_reg == RXLS_OFF_IRQ_CLR);
  wire wr_en = do_write && (awaddr_reg == RXLS_OFF_IRQ_EN);
  wire wr_stat = do_write && (awaddr_reg == RXLS_OFF_IRQ_STAT);
  wire wr_hit = wr_rfs || wr_clr || wr_en || wr_stat;

  // Channel handshakes; one write in flight at a time.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RXLS_RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_reg <= 1'b0;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RXLS_RESP_OKAY : RXLS_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Only the control half is writable; flag bits belong to hardware.
  // Software reset is deliberately not wired into this register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_reg <= RXLS_CTRL_RST;
    end else if (wr_rfs && wstrb_reg[1]) begin
      ctrl_reg <= wdata_reg[15:9];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  wire [RXLS_IRQ_W-1:0] irq_events = {
    st.done && st.flags[RXLS_BIT_LAST],
    st.err,
    st.ok,
    st.done
  };
  wire [RXLS_IRQ_W-1:0] irq_clr_bits =
    (wr_clr && wstrb_reg[0]) ? wdata_reg[RXLS_IRQ_W-1:0] : RXLS_IRQ_RST;
  // A new event in the clearing cycle survives the clear.
  wire [RXLS_IRQ_W-1:0] irq_stat_next =
    (irq_stat_reg & ~irq_clr_bits) | irq_events;

  // Sticky status, enable mask and the level output.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_stat_reg <= RXLS_IRQ_RST;
      irq_en_reg <= RXLS_IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_en && wstrb_reg[0]) begin
        irq_en_reg <= wdata_reg[RXLS_IRQ_W-1:0];
      end
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic arready_reg, rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  wire ar_hs = s_axi_arvalid && arready_reg;
  wire rd_rfs = (s_axi_araddr == RXLS_OFF_RFS);
  wire rd_stat = (s_axi_araddr == RXLS_OFF_IRQ_STAT);
  wire rd_clr = (s_axi_araddr == RXLS_OFF_IRQ_CLR);
  wire rd_en = (s_axi_araddr == RXLS_OFF_IRQ_EN);
  wire [31:0] rd_word;
  wire rd_hit;

  // Clear register is write-only and reads as zero.
  assign rd_word =
    rd_rfs ? {16'h0000, rfs_value} :
    rd_stat ? {28'h0000000, irq_stat_reg} :
    rd_en ? {28'h0000000, irq_en_reg} :
    32'h00000000;
  assign rd_hit = rd_rfs || rd_stat || rd_clr || rd_en;

  // Read data is captured at the address handshake.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RXLS_RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? RXLS_RESP_OKAY : RXLS_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Loopback steering and descriptor write-back
  // ---------------------------------------------------------------
  // Registered one-hot select, so the line side needs no decoder.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      loopback_mac <= 1'b0;
      loopback_line_encoder_decoder <= 1'b0;
      loopback_xcvr <= 1'b0;
    end else begin
      loopback_mac <= (st.lb_mode == RXLS_LB_MAC);
      loopback_line_encoder_decoder <= (st.lb_mode == RXLS_LB_LINE_ENCODER_DECODER);
      loopback_xcvr <= (st.lb_mode == RXLS_LB_XCVR);
    end
  end

  // The whole register, flags of the finished frame included.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      descriptor_status_word <= 16'h0000;
      descriptor_status_valid <= 1'b0;
    end else begin
      descriptor_status_valid <= st.accepted;
      if (st.accepted) begin
        descriptor_status_word <= rfs_value;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule

// file: test/rxls_top_asserts.sv
`timescale 1ns/1ps
module rxls_top_asserts
  import rxls_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rx_frame_start,
  input wire logic rx_frame_end,
  input wire logic rx_byte_valid,
  input wire logic rx_dest_multicast,
  input wire logic rx_dest_broadcast,
  input wire logic rx_crc_bad,
  input wire logic rx_odd_bits,
  input wire logic rx_collision,
  input wire logic rx_accept,
  input wire logic [15:0] remaining_buffer_words,
  input wire logic [15:0] end_of_buffer_threshold,
  input wire logic loopback_mac,
  input wire logic loopback_line_encoder_decoder,
  input wire logic loopback_xcvr,
  input wire logic [RXLS_REG_W-1:0] descriptor_status_word,
  input wire logic descriptor_status_valid,
  input wire logic irq
);
  // ---------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------
  logic in_frame_reg;
  logic col_reg;
  logic [15:0] cnt_reg;
  wire [15:0] dsw = descriptor_status_word;
  wire col_any = col_reg | rx_collision;
  wire [15:0] bytes = cnt_reg + {15'h0000, rx_byte_valid};
  wire ev = rx_frame_end & in_frame_reg & rx_accept;
  wire good = !rx_crc_bad & !col_any & (bytes >= 16'h0040);
  wire [3:0] lb_dec = 4'h1 << dsw[10:9];

  // Mirrors the frame span so that an end without a start is ignored.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_frame_reg <= 1'b0;
      col_reg <= 1'b0;
      cnt_reg <= 16'h0000;
    end else if (rx_frame_start) begin
      in_frame_reg <= 1'b1;
      col_reg <= rx_collision;
      cnt_reg <= {15'h0000, rx_byte_valid};
    end else begin
      in_frame_reg <= in_frame_reg & !rx_frame_end;
      col_reg <= col_any;
      cnt_reg <= bytes;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // Descriptor word against the frame two cycles before
  // ---------------------------------------------------------------
  property p_desc;
    ev |-> ##2 descriptor_status_valid;
  endproperty
  a_desc: assert property (p_desc)
    else $error("no descriptor word for accepted frame");
  property p_mc;
    ev |-> ##2 (dsw[8] == $past(rx_dest_multicast, 2));
  endproperty
  a_mc: assert property (p_mc)
    else $error("multicast flag wrong");
  property p_bc;
    ev |-> ##2 (dsw[7] == $past(rx_dest_broadcast, 2));
  endproperty
  a_bc: assert property (p_bc)
    else $error("broadcast flag wrong");
  property p_last;
    ev |-> ##2 (dsw[6] == $past(remaining_buffer_words <=
                                 end_of_buffer_threshold, 2));
  endproperty
  a_last: assert property (p_last)
    else $error("last in buffer flag wrong");
  property p_col;
    ev |-> ##2 (dsw[4] == $past(col_any, 2));
  endproperty
  a_col: assert property (p_col)
    else $error("collision flag wrong");
  property p_crc;
    ev |-> ##2 (dsw[3] == $past(rx_crc_bad & !rx_odd_bits, 2));
  endproperty
  a_crc: assert property (p_crc)
    else $error("checksum flag wrong");
  property p_align;
    ev |-> ##2 (dsw[2] == $past(rx_crc_bad & rx_odd_bits, 2));
  endproperty
  a_align: assert property (p_align)
    else $error("alignment flag wrong");
  property p_ok;
    ev |-> ##2 (dsw[0] == $past(good, 2));
  endproperty
  a_ok: assert property (p_ok)
    else $error("received ok flag wrong");
  property p_lbk;
    descriptor_status_valid |-> (dsw[1] == (dsw[0] & (dsw[10:9] != 2'b00)));
  endproperty
  a_lbk: assert property (p_lbk)
    else $error("loopback received flag wrong");
  property p_lbsel;
    descriptor_status_valid |->
      ({1'b0, loopback_xcvr, loopback_line_encoder_decoder, loopback_mac} == lb_dec >> 1);
  endproperty
  a_lbsel: assert property (p_lbsel)
    else $error("loopback steering wrong");

  cover property (ev ##2 dsw[0]);
  cover property (ev ##2 dsw[2]);
  cover property ($rose(irq));
endmodule

bind rxls_top rxls_top_asserts chk_u (.*);

// file: test/rxls_net_model.sv
`timescale 1ns/1ps
module rxls_net_model (
  input wire logic ref_clk,
  output logic rx_frame_start,
  output logic rx_frame_end,
  output logic rx_byte_valid,
  output logic rx_dest_multicast,
  output logic rx_dest_broadcast,
  output logic rx_crc_bad,
  output logic rx_odd_bits,
  output logic rx_collision,
  output logic rx_accept,
  output logic [15:0] remaining_buffer_words,
  output logic [15:0] end_of_buffer_threshold,
  output logic carrier_sense_pin
);
  // Frame levels; lv is {mc, bc, crc, odd, accept}.
  task automatic put(input logic [4:0] lv, input logic [15:0] rbw,
                     input logic [15:0] eob);
    {rx_dest_multicast, rx_dest_broadcast, rx_crc_bad, rx_odd_bits,
     rx_accept} <= lv;
    remaining_buffer_words <= rbw;
    end_of_buffer_threshold <= eob;
  endtask

  // Idle line: no frame, no carrier.
  initial begin
    {rx_frame_start, rx_frame_end, rx_byte_valid, rx_collision} = 4'h0;
    carrier_sense_pin = 1'b0;
    put(5'h00, 16'h0000, 16'h0000);
  end

  // One frame of n bytes; levels show their inverse outside the closing
  // cycle, so sampling them at the wrong moment fails.
  task automatic send(input int n, input logic [4:0] lv, input logic col,
                      input logic [15:0] rbw, input logic [15:0] eob);
    @(posedge ref_clk);
    rx_frame_start <= 1'b1;
    rx_byte_valid <= 1'b1;
    rx_collision <= col;
    carrier_sense_pin <= 1'b1;
    put(~lv, ~rbw, ~eob);
    for (int i = 1; i < n; i++) begin
      @(posedge ref_clk);
      rx_frame_start <= 1'b0;
      rx_collision <= 1'b0;
      if (i == n - 1) begin
        rx_frame_end <= 1'b1;
        put(lv, rbw, eob);
      end
    end
    @(posedge ref_clk);
    rx_frame_end <= 1'b0;
    rx_byte_valid <= 1'b0;
    carrier_sense_pin <= 1'b0;
    put(~lv, ~rbw, ~eob);
  endtask

  // Carrier from other stations on the medium, outside any frame.
  task automatic carrier(input logic lvl);
    @(posedge ref_clk);
    carrier_sense_pin <= lvl;
  endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rxls_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic soft_rst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, rx_frame_start, rx_frame_end, rx_byte_valid;
  wire rx_dest_multicast, rx_dest_broadcast, rx_crc_bad, rx_odd_bits;
  wire rx_collision, rx_accept, carrier_sense_pin, irq;
  wire loopback_mac, loopback_line_encoder_decoder, loopback_xcvr;
  wire descriptor_status_valid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] remaining_buffer_words, end_of_buffer_threshold;
  wire [15:0] descriptor_status_word;
  logic [15:0] desc_q = 16'h0000;
  int desc_n = 0;
  int error_cnt = 0;
  int n_tests = 0;

  rxls_top dut_u (.*);
  rxls_net_model net_u (.*);

  always #5 ref_clk = ~ref_clk;

  // Last descriptor word and how many were written.
  always @(posedge ref_clk) begin
    if (descriptor_status_valid === 1'b1) begin
      desc_q <= descriptor_status_word;
      desc_n <= desc_n + 1;
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r = RXLS_RESP_OKAY);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask

  // Reads one word and compares the bits selected by m.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m,
                        input logic [1:0] r = RXLS_RESP_OKAY);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    chk($sformatf("word at %h", a), e & m, s_axi_rdata & m);
  endtask

  // Expected flags of one frame; the carrier bit is checked apart.
  function automatic logic [8:0] flags(input int n, input logic [4:0] lv,
                                       input logic col,
                                       input logic [15:0] rbw,
                                       input logic [15:0] eob,
                                       input logic [1:0] lb);
    logic ok;
    ok = !lv[2] && !col && n >= RXLS_RUNT_BYTES;
    return {lv[4], lv[3], rbw <= eob, 1'b0, col, lv[2] & !lv[1],
            lv[2] & lv[1], ok && lb != 2'b00, ok};
  endfunction

  // One frame in mode lb, all filters on; flags are wiped mid-frame.
  task automatic run_case(input int n, input logic [4:0] lv,
                          input logic col, input logic [15:0] rbw,
                          input logic [15:0] eob, input logic [1:0] lb);
    logic [15:0] w;
    int d0;
    w = {5'h1F, lb, flags(n, lv, col, rbw, eob, lb)};
    wr(RXLS_OFF_RFS, {16'h0, w & 16'hFE00}, 4'h3);
    wr(RXLS_OFF_IRQ_CLR, 32'hF, 4'h1);
    d0 = desc_n;
    fork
      net_u.send(n, lv, col, rbw, eob);
      begin
        repeat (10) @(posedge ref_clk);
        rd_chk(RXLS_OFF_RFS, {16'h0, w & 16'hFE00}, 32'hFFCF);
      end
    join
    rd_chk(RXLS_OFF_RFS, {16'h0, w}, 32'hFFDF);
    chk("descriptor count", d0 + lv[0], desc_n);
    if (lv[0]) begin
      chk("descriptor", {16'h0, w & 16'hFFDF},
          {16'h0, desc_q & 16'hFFDF});
      rd_chk(RXLS_OFF_IRQ_STAT, {28'h0, w[6], 1'b0, w[0], 1'b1}, 32'hB);
      chk("irq line", 32'h1, {31'h0, irq});
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(RXLS_OFF_RFS, 32'h0, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'h0, 32'hFFFFFFFF, RXLS_RESP_SLVERR);
    rd_chk(RXLS_OFF_IRQ_CLR, 32'h0, 32'hFFFFFFFF);
    // Mode 3 also needs data_config_second bit 6, held outside this block.
    for (int m = 0; m < 4; m++) begin
      wr(RXLS_OFF_RFS, {16'h0, 5'h1F, 2'(m), 9'h1FF}, 4'h3);
      rd_chk(RXLS_OFF_RFS, {16'h0, 5'h1F, 2'(m), 9'h0}, 32'hFFFF);
      chk("loopback", {28'h0, 4'(4'h1 << m) >> 1},
          {29'h0, loopback_xcvr, loopback_line_encoder_decoder, loopback_mac});
    end
    soft_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    soft_rst <= 1'b0;
    rd_chk(RXLS_OFF_RFS, 32'hFE00, 32'hFFFF);
    wr(RXLS_OFF_IRQ_EN, 32'h1, 4'h1);
    wr(RXLS_OFF_IRQ_STAT, 32'hF, 4'h1);
    rd_chk(RXLS_OFF_IRQ_STAT, 32'h0, 32'hF);
    run_case(64, 5'b10001, 1'b0, 16'd10, 16'd10, 2'd1);
    run_case(63, 5'b01001, 1'b0, 16'd11, 16'd10, 2'd1);
    run_case(64, 5'b00101, 1'b0, 16'd0, 16'd5, 2'd2);
    run_case(64, 5'b00111, 1'b0, 16'd5, 16'd0, 2'd3);
    run_case(70, 5'b00011, 1'b0, 16'd5, 16'd0, 2'd0);
    run_case(64, 5'b11000, 1'b0, 16'd5, 16'd0, 2'd2);
    run_case(64, 5'b00001, 1'b1, 16'd5, 16'd0, 2'd0);
    wr(RXLS_OFF_IRQ_EN, 32'h0, 4'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(RXLS_OFF_IRQ_EN, 32'h1, 4'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(RXLS_OFF_IRQ_CLR, 32'hF, 4'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd_chk(RXLS_OFF_IRQ_STAT, 32'h0, 32'hF);
    net_u.carrier(1'b1);
    repeat (5) @(posedge ref_clk);
    rd_chk(RXLS_OFF_RFS, 32'h20, 32'h20);
    net_u.carrier(1'b0);
    repeat (5) @(posedge ref_clk);
    rd_chk(RXLS_OFF_RFS, 32'h0, 32'h20);
    give_verdict();
  end

  // Under a thousand cycles suffice; this is ample.
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end
endmodule
